// ---- design/asr_map.svh ----
/*
  Register indices, field positions, reset values and timing figures of the
  sample-rate and tilt-debounce block.
  Assumes a 100 MHz clock; included by its bare name by every design file except the type package.
*/
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH

////////////////////////////////////////////////////////////////////////////
// Clock and sample periods, in ns
`define ASR_CLK_NS 10
`define ASR_T_120_NS 8360000
`define ASR_T_64_NS 15625000
`define ASR_T_32_NS 31250000
`define ASR_T_16_NS 62500000
`define ASR_T_8_NS 125000000
`define ASR_T_4_NS 250000000
`define ASR_T_2_NS 500000000
`define ASR_T_1_NS 1000000000
`define ASR_CNT_W 27

////////////////////////////////////////////////////////////////////////////
// Register word indices; byte address is four times the index
`define ASR_IDX_X 6'h00
`define ASR_IDX_Y 6'h01
`define ASR_IDX_Z 6'h02
`define ASR_IDX_TILT 6'h03
`define ASR_IDX_SR 6'h08
`define ASR_IDX_CTRL 6'h0F

// Rate register fields and reset
`define ASR_SR_ACT 2:0
`define ASR_SR_WAKE 4:3
`define ASR_SR_DEB 7:5
`define ASR_SR_RST 8'h00
// Control register fields
`define ASR_CTL_RUN 0
`define ASR_CTL_WAKE 1
`define ASR_CTL_TAP 2

// Rate codes
`define ASR_AM_120 3'h0
`define ASR_AM_64 3'h1
`define ASR_AM_32 3'h2
`define ASR_AM_16 3'h3
`define ASR_AM_8 3'h4
`define ASR_AM_4 3'h5
`define ASR_AM_2 3'h6
`define ASR_AM_1 3'h7
`define ASR_AW_32 2'h0
`define ASR_AW_16 2'h1
`define ASR_AW_8 2'h2
`define ASR_AW_1 2'h3

// Averaging and orientation codes
`define ASR_AVG_N 32
`define ASR_OR_NONE 2'h0
`define ASR_OR_X 2'h1
`define ASR_OR_Y 2'h2
`define ASR_OR_Z 2'h3

`endif

// ---- design/asr_pkg.sv ----
/*
  Types shared by the sample-rate block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package asr_pkg;
  typedef enum logic {
    AVG_IDLE,
    AVG_ACC
  } asr_avg_state_t;
  typedef logic [2:0] asr_orient_t;
endpackage : asr_pkg

// ---- design/asr_avg.sv ----
/*
  Averager: on start, takes the next N cell readings and outputs the mean.
  Assumes cell readings are signed and marked by cell_valid.
*/
`include "asr_map.svh"
module asr_avg #(
  parameter int N = `ASR_AVG_N,
  parameter int W = 6
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic cell_valid,
  input wire logic signed [W-1:0] cell_x,
  input wire logic signed [W-1:0] cell_y,
  input wire logic signed [W-1:0] cell_z,
  output logic busy,
  output logic done,
  output logic signed [W-1:0] avg_x,
  output logic signed [W-1:0] avg_y,
  output logic signed [W-1:0] avg_z
);
  localparam int SH = $clog2(N);
  localparam int SW = W + SH;
  asr_pkg::asr_avg_state_t state_ff;
  logic [SH-1:0] cnt_ff;
  logic signed [SW-1:0] sx_ff, sy_ff, sz_ff;
  logic last;
  assign last = cell_valid && cnt_ff == SH'(N - 1);
  assign busy = state_ff == asr_pkg::AVG_ACC;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= asr_pkg::AVG_IDLE;
    end else begin
      unique case (state_ff)
        asr_pkg::AVG_IDLE: if (start) state_ff <= asr_pkg::AVG_ACC;
        asr_pkg::AVG_ACC: if (last) state_ff <= asr_pkg::AVG_IDLE;
      endcase
    end
  end

  // Sum of all N readings, then a shift; N is a power of two
  always_ff @(posedge clk) begin
    if (sys_rst || (start && !busy)) begin
      cnt_ff <= '0;
      sx_ff <= '0;
      sy_ff <= '0;
      sz_ff <= '0;
    end else if (busy && cell_valid) begin
      cnt_ff <= cnt_ff + 1'b1;
      sx_ff <= sx_ff + SW'(cell_x);
      sy_ff <= sy_ff + SW'(cell_y);
      sz_ff <= sz_ff + SW'(cell_z);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done <= 1'b0;
      avg_x <= '0;
      avg_y <= '0;
      avg_z <= '0;
    end else begin
      done <= busy && last;
      if (busy && last) begin
        avg_x <= W'((sx_ff + SW'(cell_x)) >>> SH);
        avg_y <= W'((sy_ff + SW'(cell_y)) >>> SH);
        avg_z <= W'((sz_ff + SW'(cell_z)) >>> SH);
      end
    end
  end

  avg_count_a: assert property (@(posedge clk) disable iff (sys_rst)
    done |-> $past(cnt_ff) == SH'(N - 1) && $past(cell_valid))
    else $error("average finished before all readings were taken");
endmodule : asr_avg

// ---- design/asr_deb.sv ----
/*
  Orientation debounce: the result follows the input only after len+1
  consecutive samples agree.
  Assumes smp is a one-cycle pulse per averaged sample.
*/
`include "asr_map.svh"
module asr_deb (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic smp,
  input wire asr_pkg::asr_orient_t orient_in,
  input wire logic [2:0] len,
  output asr_pkg::asr_orient_t orient_out
);
  asr_pkg::asr_orient_t last_ff;
  logic [3:0] match_ff;
  logic [3:0] nxt_match;
  always_comb begin
    nxt_match = 4'h1;
    if (orient_in == last_ff && match_ff != 4'h8) nxt_match = match_ff + 4'h1;
    else if (orient_in == last_ff) nxt_match = match_ff;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      last_ff <= '0;
      match_ff <= '0;
      orient_out <= '0;
    end else if (smp) begin
      last_ff <= orient_in;
      match_ff <= nxt_match;
      if (nxt_match >= {1'b0, len} + 4'h1) orient_out <= orient_in;
    end
  end

  no_filter_a: assert property (@(posedge clk) disable iff (sys_rst)
    smp && len == 3'h0 |=> orient_out == $past(orient_in))
    else $error("unfiltered orientation did not follow the sample");
  restart_a: assert property (@(posedge clk) disable iff (sys_rst)
    smp && orient_in != last_ff |=> match_ff == 4'h1)
    else $error("match count did not restart on a differing sample");
  enough_match_a: assert property (@(posedge clk) disable iff (sys_rst)
    smp && orient_out != orient_in |=> orient_out == $past(orient_out)
      || match_ff >= {1'b0, $past(len)} + 4'h1)
    else $error("orientation updated with too few matching samples");
endmodule : asr_deb

// ---- design/asr_top.sv ----
/*
  Sample-rate timebase, sample averaging and orientation debounce,
  with an APB register slave.
  Assumes a 100 MHz clock, cell readings synchronous to it, and a zero-wait
  APB master.
*/
// The address map and the APB slave port were left to the implementer.
// Summary of operation
// - Active code 011 gives one averaged sample every 62.5 ms.
// - Active code 100 gives one averaged sample every 125 ms.
// - Active code 101 gives one averaged sample every 250 ms.
// - Active code 110 gives one averaged sample every 500 ms.
// - Active code 111 gives one averaged sample every 1000 ms.
// - Each sample averages 32 readings and refreshes X, Y and Z outputs.
// - Wake code 00 gives one sample every 31.25 ms in auto-wake.
// - Wake code 01 gives one sample every 62.5 ms in auto-wake.
// - Wake code 10 gives one sample every 125 ms in auto-wake.
// - Wake code 11 gives one sample every 1000 ms in auto-wake.
// - Filter code 000: orientation updates on every sample.
// - Filter codes 1..7 need code plus one matching samples to update.
// - The filter counts samples at whichever rate is in force.
// - Active code 000 gives a sample every 8.36 ms with tap mode on.
// - Auto-wake uses the wake rate; leaving it switches to active rate.
`include "asr_map.svh"
module asr_top #(
  parameter int CYC_120 = `ASR_T_120_NS / `ASR_CLK_NS,
  parameter int CYC_64 = `ASR_T_64_NS / `ASR_CLK_NS,
  parameter int CYC_32 = `ASR_T_32_NS / `ASR_CLK_NS,
  parameter int CYC_16 = `ASR_T_16_NS / `ASR_CLK_NS,
  parameter int CYC_8 = `ASR_T_8_NS / `ASR_CLK_NS,
  parameter int CYC_4 = `ASR_T_4_NS / `ASR_CLK_NS,
  parameter int CYC_2 = `ASR_T_2_NS / `ASR_CLK_NS,
  parameter int CYC_1 = `ASR_T_1_NS / `ASR_CLK_NS,
  parameter int AVG_N = `ASR_AVG_N,
  parameter int W = 6
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cell_valid,
  input wire logic signed [W-1:0] cell_x,
  input wire logic signed [W-1:0] cell_y,
  input wire logic signed [W-1:0] cell_z,
  input wire logic wake_exit,
  output logic cell_req,
  output logic sample_done,
  output logic tap_mode
);
  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic mapped(input logic [5:0] idx);
    mapped = idx == `ASR_IDX_X || idx == `ASR_IDX_Y || idx == `ASR_IDX_Z
      || idx == `ASR_IDX_TILT || idx == `ASR_IDX_SR
      || idx == `ASR_IDX_CTRL;
  endfunction : mapped

  // Cycles per sample for the rate in force
  function automatic logic [`ASR_CNT_W-1:0] rate_cycles(
      input logic wake, input logic [7:0] sr);
    int c;
    c = CYC_1;
    if (wake) begin
      unique case (sr[`ASR_SR_WAKE])
        `ASR_AW_32: c = CYC_32;
        `ASR_AW_16: c = CYC_16;
        `ASR_AW_8: c = CYC_8;
        `ASR_AW_1: c = CYC_1;
      endcase
    end else begin
      unique case (sr[`ASR_SR_ACT])
        `ASR_AM_120: c = CYC_120;
        `ASR_AM_64: c = CYC_64;
        `ASR_AM_32: c = CYC_32;
        `ASR_AM_16: c = CYC_16;
        `ASR_AM_8: c = CYC_8;
        `ASR_AM_4: c = CYC_4;
        `ASR_AM_2: c = CYC_2;
        `ASR_AM_1: c = CYC_1;
      endcase
    end
    rate_cycles = `ASR_CNT_W'(c);
  endfunction : rate_cycles

  function automatic logic [W-1:0] mag(input logic signed [W-1:0] v);
    mag = v[W-1] ? W'(-v) : v;
  endfunction : mag

  // Dominant axis and its sign
  function automatic asr_pkg::asr_orient_t orient(
      input logic signed [W-1:0] x, input logic signed [W-1:0] y,
      input logic signed [W-1:0] z);
    orient = {`ASR_OR_NONE, 1'b0};
    if (mag(x) >= mag(y) && mag(x) >= mag(z) && x != '0)
      orient = {`ASR_OR_X, x[W-1]};
    else if (mag(y) >= mag(z) && y != '0) orient = {`ASR_OR_Y, y[W-1]};
    else if (z != '0) orient = {`ASR_OR_Z, z[W-1]};
  endfunction : orient

  ////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  logic [7:0] sr_ff;
  logic run_ff;
  logic wake_ff;
  logic signed [W-1:0] x_ff, y_ff, z_ff;
  asr_pkg::asr_orient_t tilt;
  logic [5:0] idx;
  logic acc;
  logic wr;
  assign idx = paddr[7:2];
  assign pready = 1'b1;
  assign acc = psel && penable;
  assign wr = acc && pwrite && mapped(idx);
  assign pslverr = acc && !mapped(idx);

  // Read data latched in the setup cycle so it leaves a flip-flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      if (idx == `ASR_IDX_X) prdata <= 32'(unsigned'(x_ff));
      if (idx == `ASR_IDX_Y) prdata <= 32'(unsigned'(y_ff));
      if (idx == `ASR_IDX_Z) prdata <= 32'(unsigned'(z_ff));
      if (idx == `ASR_IDX_TILT) prdata <= 32'(tilt);
      if (idx == `ASR_IDX_SR) prdata <= 32'(sr_ff);
      if (idx == `ASR_IDX_CTRL) prdata <= 32'({tap_mode, wake_ff, run_ff});
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sr_ff <= `ASR_SR_RST;
    end else if (wr && idx == `ASR_IDX_SR) begin
      sr_ff <= pwdata[7:0];
    end
  end

  // The exit event beats a same-cycle write so a wake-up is never lost
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else begin
      if (wr && idx == `ASR_IDX_CTRL) begin
        run_ff <= pwdata[`ASR_CTL_RUN];
        wake_ff <= pwdata[`ASR_CTL_WAKE];
      end
      if (wake_exit) wake_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timebase
  logic [`ASR_CNT_W-1:0] cnt_ff;
  logic [`ASR_CNT_W-1:0] period;
  logic [3:0] key, key_ff;
  logic restart;
  logic tick;
  assign period = rate_cycles(wake_ff, sr_ff);
  assign key = wake_ff ? {2'b10, sr_ff[`ASR_SR_WAKE]}
    : {1'b0, sr_ff[`ASR_SR_ACT]};
  assign restart = key != key_ff || !run_ff;
  assign tick = !restart && cnt_ff == period - 1'b1;
  assign tap_mode = run_ff && !wake_ff
    && sr_ff[`ASR_SR_ACT] == `ASR_AM_120;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      key_ff <= '0;
      cnt_ff <= '0;
    end else begin
      key_ff <= key;
      if (restart || tick) cnt_ff <= '0;
      else cnt_ff <= cnt_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Averaging and output registers
  logic avg_done;
  logic signed [W-1:0] ax, ay, az;
  asr_avg #(
    .N(AVG_N),
    .W(W)
  ) u_avg (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(tick),
    .cell_valid(cell_valid),
    .cell_x(cell_x),
    .cell_y(cell_y),
    .cell_z(cell_z),
    .busy(cell_req),
    .done(avg_done),
    .avg_x(ax),
    .avg_y(ay),
    .avg_z(az)
  );

  // A very slow cell source may miss a tick; that sample is skipped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      x_ff <= '0;
      y_ff <= '0;
      z_ff <= '0;
      sample_done <= 1'b0;
    end else begin
      sample_done <= avg_done;
      if (avg_done) begin
        x_ff <= ax;
        y_ff <= ay;
        z_ff <= az;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Orientation debounce on samples at the rate in force
  asr_deb u_deb (
    .clk(clk),
    .sys_rst(sys_rst),
    .smp(sample_done),
    .orient_in(orient(x_ff, y_ff, z_ff)),
    .len(sr_ff[`ASR_SR_DEB]),
    .orient_out(tilt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_wr_sr;
    psel && penable && pwrite && idx == `ASR_IDX_SR;
  endsequence
  sequence s_exit;
    wake_exit ##1 !wake_ff;
  endsequence

  sr_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_wr_sr |=> sr_ff == $past(pwdata[7:0]))
    else $error("rate register write was lost");
  tick_restart_a: assert property (@(posedge clk) disable iff (sys_rst)
    tick |=> cnt_ff == '0)
    else $error("timebase did not restart after a tick");
  rate_change_a: assert property (@(posedge clk) disable iff (sys_rst)
    run_ff && key != key_ff |-> !tick ##1 cnt_ff == '0)
    else $error("timebase did not restart on rate change");
  tick_period_a: assert property (@(posedge clk) disable iff (sys_rst)
    tick |-> $past(cnt_ff) == period - 2'd2 || period == 1)
    else $error("sample tick not at the end of the period");
  wake_rate_a: assert property (@(posedge clk) disable iff (sys_rst)
    wake_ff && sr_ff[`ASR_SR_WAKE] == `ASR_AW_32 |-> period
      == `ASR_CNT_W'(CYC_32))
    else $error("auto-wake rate not in force");
  wake_exit_a: assert property (@(posedge clk) disable iff (sys_rst)
    wake_exit |-> s_exit ##0 period == rate_cycles(1'b0, sr_ff))
    else $error("active rate not restored after wake exit");
  out_update_a: assert property (@(posedge clk) disable iff (sys_rst)
    avg_done |=> x_ff == $past(ax) && sample_done)
    else $error("axis output not refreshed by sample");
  tap_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
    tap_mode |-> period == `ASR_CNT_W'(CYC_120))
    else $error("tap mode without the fastest rate");

  ////////////////////////////////////////////////////////////////////////
  // Rate checks straight from the parameters, so a wrong map in
  // rate_cycles cannot hide behind its own result
  sequence s_act_tick(logic [2:0] code);
    tick && !wake_ff && sr_ff[`ASR_SR_ACT] == code;
  endsequence
  sequence s_wake_tick(logic [1:0] code);
    tick && wake_ff && sr_ff[`ASR_SR_WAKE] == code;
  endsequence

  act64_period_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_act_tick(`ASR_AM_64) |-> cnt_ff == `ASR_CNT_W'(CYC_64 - 1))
    else $error("active 64 per second period wrong");
  act32_period_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_act_tick(`ASR_AM_32) |-> cnt_ff == `ASR_CNT_W'(CYC_32 - 1))
    else $error("active 32 per second period wrong");
  act16_period_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_act_tick(`ASR_AM_16) |-> cnt_ff == `ASR_CNT_W'(CYC_16 - 1))
    else $error("active 16 per second period wrong");
  act8_period_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_act_tick(`ASR_AM_8) |-> cnt_ff == `ASR_CNT_W'(CYC_8 - 1))
    else $error("active 8 per second period wrong");
  act4_period_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_act_tick(`ASR_AM_4) |-> cnt_ff == `ASR_CNT_W'(CYC_4 - 1))
    else $error("active 4 per second period wrong");
  act2_period_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_act_tick(`ASR_AM_2) |-> cnt_ff == `ASR_CNT_W'(CYC_2 - 1))
    else $error("active 2 per second period wrong");
  act1_period_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_act_tick(`ASR_AM_1) |-> cnt_ff == `ASR_CNT_W'(CYC_1 - 1))
    else $error("active 1 per second period wrong");
  wake16_period_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_wake_tick(`ASR_AW_16) |-> cnt_ff == `ASR_CNT_W'(CYC_16 - 1))
    else $error("wake 16 per second period wrong");
  wake8_period_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_wake_tick(`ASR_AW_8) |-> cnt_ff == `ASR_CNT_W'(CYC_8 - 1))
    else $error("wake 8 per second period wrong");
  wake1_period_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_wake_tick(`ASR_AW_1) |-> cnt_ff == `ASR_CNT_W'(CYC_1 - 1))
    else $error("wake 1 per second period wrong");

  // Readings taken per sample, counted apart from the averager
  localparam int GW = $clog2(AVG_N) + 1;
  logic [GW-1:0] got_ff;
  always_ff @(posedge clk) begin
    if (sys_rst || !cell_req) begin
      got_ff <= '0;
    end else if (cell_valid) begin
      got_ff <= got_ff + 1'b1;
    end
  end
  sequence s_avg_end;
    cell_req ##1 !cell_req;
  endsequence

  avg_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_avg_end |-> got_ff == GW'(AVG_N) && avg_done)
    else $error("sample not made of the full set of readings");
  req_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    tick && !cell_req |=> cell_req)
    else $error("averaging did not start on the tick");

  xyz_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !avg_done |=> $stable(x_ff) && $stable(y_ff) && $stable(z_ff))
    else $error("axis output changed without a sample");
  tilt_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !sample_done |=> $stable(tilt))
    else $error("orientation changed between samples");
  stop_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    !run_ff |-> !tick ##1 cnt_ff == '0)
    else $error("timebase ran while stopped");
  tap_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    wake_ff || !run_ff |-> !tap_mode)
    else $error("tap mode outside active operation");
endmodule : asr_top

// ---- test/asr_tb_top.sv ----
/*
  Self-checking bench for the sample-rate timebase, averaging and tilt
  debounce block, driven through its APB slave.
  Assumes short sample periods given as parameters and cell readings
  driven by this bench on every cycle.
*/
`include "asr_map.svh"
`define TB_CHK(a, e) \
  begin \
    n_compared++; \
    if ((a) !== (e)) begin \
      fail_count++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
  end

module accel_sample_rate_tilt_debounce_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////
  // Short periods keep the run small; distinct values expose a wrong map
  localparam int PER_A [8] = '{40, 48, 56, 64, 72, 80, 88, 96};
  localparam int PER_W [4] = '{56, 64, 72, 96};

  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cell_valid = 1'b1;
  logic signed [5:0] cell_x = 6'h00;
  logic signed [5:0] cell_y = 6'h00;
  logic signed [5:0] cell_z = 6'h00;
  logic wake_exit = 1'b0;
  logic cell_req;
  logic sample_done;
  logic tap_mode;
  logic signed [5:0] xa_ff = 6'h00;
  logic signed [5:0] xb_ff = 6'h00;
  logic alt_ff = 1'b0;
  int fail_count = 0;
  int n_compared = 0;

  asr_top #(
    .CYC_120(PER_A[0]), .CYC_64(PER_A[1]), .CYC_32(PER_A[2]),
    .CYC_16(PER_A[3]), .CYC_8(PER_A[4]), .CYC_4(PER_A[5]),
    .CYC_2(PER_A[6]), .CYC_1(PER_A[7])
  ) DUT (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cell_valid(cell_valid),
    .cell_x(cell_x), .cell_y(cell_y), .cell_z(cell_z),
    .wake_exit(wake_exit), .cell_req(cell_req),
    .sample_done(sample_done), .tap_mode(tap_mode)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  // X alternates between two values so the mean differs from either one
  always @(posedge clk) begin
    alt_ff <= ~alt_ff;
    cell_x <= alt_ff ? xb_ff : xa_ff;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [5:0] idx,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask : wr

  task automatic chk_reg(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0000_0000, r, e);
    `TB_CHK(r, exp)
    `TB_CHK(e, 1'b0)
  endtask : chk_reg

  task automatic tilt_axis(input logic [1:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, `ASR_IDX_TILT, 32'h0000_0000, r, e);
    `TB_CHK(r[2:1], exp)
  endtask : tilt_axis

  task automatic set_cell(input logic signed [5:0] a, b, y, z);
    @(posedge clk);
    xa_ff <= a;
    xb_ff <= b;
    cell_y <= y;
    cell_z <= z;
  endtask : set_cell

  // Checked at the falling edge, where the pulse has settled
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (sample_done !== 1'b1 && n < 2000);
    if (n >= 2000) fail_count++;
  endtask : wait_done

  // The first two samples after a change may still carry the old period
  task automatic per(input int exp);
    int n;
    repeat (3) wait_done(n);
    `TB_CHK(n, exp)
  endtask : per

  ////////////////////////////////////////////////////////////////////////
  task automatic t_avg;
    logic [31:0] r;
    logic e;
    set_cell(6'h0A, 6'h14, 6'h05, 6'h2C);
    wr(`ASR_IDX_SR, 32'h0000_0003);
    wr(`ASR_IDX_CTRL, 32'h0000_0001);
    per(PER_A[3]);
    chk_reg(`ASR_IDX_X, 32'h0000_000F);
    chk_reg(`ASR_IDX_Y, 32'h0000_0005);
    chk_reg(`ASR_IDX_Z, 32'h0000_002C);
    chk_reg(`ASR_IDX_TILT, 32'h0000_0007);
    wr(`ASR_IDX_X, 32'h0000_0015);
    chk_reg(`ASR_IDX_X, 32'h0000_000F);
    apb(1'b0, 6'h3E, 32'h0000_0000, r, e);
    `TB_CHK({e, r}, 33'h1_0000_0000)
    set_cell(6'h02, 6'h02, 6'h14, 6'h02);
    per(PER_A[3]);
    chk_reg(`ASR_IDX_TILT, 32'h0000_0004);
    $display("averaging test done");
  endtask : t_avg

  task automatic t_rates;
    for (int c = 0; c < 8; c++) begin
      wr(`ASR_IDX_SR, {29'h0000_0000, c[2:0]});
      per(PER_A[c]);
      `TB_CHK(tap_mode, c == 0)
      chk_reg(`ASR_IDX_CTRL, {29'h0000_0000, c == 0, 2'h1});
    end
    $display("active rate test done");
  endtask : t_rates

  task automatic t_wake;
    wr(`ASR_IDX_CTRL, 32'h0000_0003);
    for (int w = 0; w < 4; w++) begin
      wr(`ASR_IDX_SR, {27'h000_0000, w[1:0], 3'h4});
      per(PER_W[w]);
    end
    @(posedge clk);
    wake_exit <= 1'b1;
    @(posedge clk);
    wake_exit <= 1'b0;
    chk_reg(`ASR_IDX_CTRL, 32'h0000_0001);
    per(PER_A[4]);
    $display("wake rate test done");
  endtask : t_wake

  // A run of len odd samples in mid-run, for len above 1, must restart the match count
  task automatic t_deb(input logic [2:0] len);
    int n;
    wr(`ASR_IDX_SR, {24'h00_0000, len, 5'h03});
    set_cell(6'h14, 6'h14, 6'h02, 6'h02);
    repeat (len + 3) wait_done(n);
    tilt_axis(2'h1);
    if (len > 1) begin
      set_cell(6'h02, 6'h02, 6'h02, 6'h14);
      repeat (len) wait_done(n);
      set_cell(6'h14, 6'h14, 6'h02, 6'h02);
      wait_done(n);
    end
    set_cell(6'h02, 6'h02, 6'h02, 6'h14);
    for (int k = 0; k <= len; k++) begin
      wait_done(n);
      tilt_axis((k == len) ? 2'h3 : 2'h1);
    end
    $display("debounce test done");
  endtask : t_deb

  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    `TB_CHK(sample_done, 1'b0)
    t_avg();
    t_rates();
    t_wake();
    t_deb(3'h0);
    t_deb(3'h2);
    t_deb(3'h7);
    wr(`ASR_IDX_CTRL, 32'h0000_0003);
    t_deb(3'h1);
    close_out();
  end

  // Whole run needs about 7000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    close_out();
  end
endmodule : accel_sample_rate_tilt_debounce_tb_top
